// File: src/ssfb_cfg.svh
// Register offsets, field positions, reset values and timing counts for the blanking block.
`ifndef SSFB_CFG_SVH
`define SSFB_CFG_SVH
// Printed register indices; byte address is four times the index.
`define SSFB_IDX_BLANK 16'hFE07
`define SSFB_IDX_CTRL 16'hFE08
`define SSFB_IDX_DEB 16'hFE09
`define SSFB_IDX_STATUS 16'hFE0F
`define SSFB_ADDR_BLANK 18'h3F81C
`define SSFB_ADDR_CTRL 18'h3F820
`define SSFB_ADDR_DEB 18'h3F824
`define SSFB_ADDR_STATUS 18'h3F83C
`define SSFB_RST_BLANK 8'h00
`define SSFB_RST_CTRL 8'h00
`define SSFB_RST_DEB 8'h00
// Control register fields.
`define SSFB_C_LINE_REEN 6
`define SSFB_C_FIRST_ID 5
`define SSFB_C_IMMED 4
`define SSFB_C_BAL 3
// Blanking register fields.
`define SSFB_B_C_OC 6
`define SSFB_B_B_OV 5
`define SSFB_B_A_OV 4
`define SSFB_B_B_OC2 3
`define SSFB_B_A_OC2 2
`define SSFB_B_B_OC1 1
`define SSFB_B_A_OC1 0
// Debounce field low bits.
`define SSFB_D_B_ON 6
`define SSFB_D_B_OFF 4
`define SSFB_D_A_ON 2
`define SSFB_D_A_OFF 0
// Debounce times in ms and cycle counts at 25 MHz.
`define SSFB_CLK_KHZ 25000
`define SSFB_T1_MS 200
`define SSFB_T2_MS 320
`define SSFB_T3_MS 600
`define SSFB_T1_CYC (`SSFB_T1_MS * `SSFB_CLK_KHZ)
`define SSFB_T2_CYC (`SSFB_T2_MS * `SSFB_CLK_KHZ)
`define SSFB_T3_CYC (`SSFB_T3_MS * `SSFB_CLK_KHZ)
`endif

// File: src/ssfb_pkg.sv
// Types shared by the soft-start fault blanking block.
package ssfb_pkg;
  // Bit order of the protection flag vector.
  typedef enum logic [3:0] {
    SSFB_F_EXT = 4'h0, SSFB_F_OT1 = 4'h1, SSFB_F_OT2 = 4'h2, SSFB_F_LINE = 4'h3,
    SSFB_F_REV_A = 4'h4, SSFB_F_REV_B = 4'h5, SSFB_F_UV_A = 4'h6, SSFB_F_UV_B = 4'h7,
    SSFB_F_OC_C = 4'h8, SSFB_F_OV_A = 4'h9, SSFB_F_OV_B = 4'hA, SSFB_F_OC2_A = 4'hB,
    SSFB_F_OC2_B = 4'hC, SSFB_F_OC1_A = 4'hD, SSFB_F_OC1_B = 4'hE
  } ssfb_flag_t;
  // Power-good debounce state, Gray coded.
  typedef enum logic [1:0] {
    SSFB_PG_OFF = 2'b00, SSFB_PG_RISE = 2'b01, SSFB_PG_ON = 2'b11, SSFB_PG_FALL = 2'b10
  } ssfb_pg_t;
  typedef struct packed {
    logic [7:0] blank;
    logic [7:0] ctrl;
    logic [7:0] deb;
    ssfb_pg_t [1:0] pg_st;
    logic [1:0][24:0] pg_cnt;
    logic [1:0] pg;
    logic [14:0] act;
    logic first_seen;
    logic [3:0] first_id;
    logic store_req;
    logic shut_now;
    logic shut_eoc;
    logic [3:0] rect_off;
    logic bal_hold;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ssfb_state_t;
endpackage : ssfb_pkg

// File: src/ssfb_top.sv
// Soft-start fault blanking, shutdown timing, rectifier gating and power-good debounce.
// Summary of operation
// - Any soft start blanks external, temp, line flags.
// - Channel A soft start blanks A reverse, undervoltage.
// - Channel B soft start blanks B reverse, undervoltage.
// - Blanked flags still set; no protective action.
// - Bit 6 zero blanks C overcurrent in soft start.
// - Bits 5,4 zero blank B/A overvoltage.
// - Bits 3,2 zero blank second-sense overcurrent.
// - Bits 1,0 zero blank first-sense overcurrent.
// - Control bit 6 blanks line flag during reenable.
// - Control bit 5 stores first flag identity.
// - Control bit 4 picks immediate or end-of-cycle shutdown.
// - Control bit 3 suspends balance during soft start.
// - Input bal_chan_sel_c picks balance channel A/C.
// - Bits 2..0 hold rectifier drives off per channel.
// - Otherwise per-output disable configuration decides.
// - Field 7:6 sets B power-good on delay.
// - Field 5:4 sets B power-good off delay.
// - Fields 3:2, 1:0 set A delays.
// - Reenable delay is global, before soft start.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ssfb_cfg.svh"

module ssfb_top
  import ssfb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] soft_start,
  input wire logic reenable_period,
  input wire logic [14:0] flag_raw,
  input wire logic pwm_cycle_end,
  input wire logic bal_chan_sel_c,
  input wire logic [3:0] rect_chan_a,
  input wire logic [3:0] rect_chan_b,
  input wire logic [3:0] rect_chan_c,
  input wire logic [3:0] rect_cfg_disable,
  input wire logic [1:0] pg_cond,
  output logic [14:0] flag_active,
  output logic shutdown_now,
  output logic shutdown_cycle_end,
  output logic first_id_store,
  output logic [3:0] first_id,
  output logic [3:0] rect_disable,
  output logic balance_suspend,
  output logic chan_a_power_good,
  output logic chan_b_power_good
);

  ssfb_state_t r;
  ssfb_state_t next_r;

  // Cycle count for a two-bit debounce code; code zero means no wait.
  function automatic logic [24:0] ssfb_deb_cycles(input logic [1:0] code);
    case (code)
      2'b01: ssfb_deb_cycles = 25'(`SSFB_T1_CYC);
      2'b10: ssfb_deb_cycles = 25'(`SSFB_T2_CYC);
      2'b11: ssfb_deb_cycles = 25'(`SSFB_T3_CYC);
      default: ssfb_deb_cycles = 25'h0000000;
    endcase
  endfunction

  logic wr_en;
  logic rd_en;
  logic [14:0] blank_mask;
  logic [14:0] acted;

  assign wr_en = psel & penable & pwrite & ~r.pready;
  assign rd_en = psel & penable & ~pwrite & ~r.pready;

  // Blanking mask from soft-start status and the blanking register.
  always_comb begin
    blank_mask = 15'h0000;
    if (|soft_start) begin
      blank_mask[SSFB_F_EXT] = 1'b1;
      blank_mask[SSFB_F_OT1] = 1'b1;
      blank_mask[SSFB_F_OT2] = 1'b1;
      blank_mask[SSFB_F_LINE] = 1'b1;
    end
    if (soft_start[0]) begin
      blank_mask[SSFB_F_REV_A] = 1'b1;
      blank_mask[SSFB_F_UV_A] = 1'b1;
      blank_mask[SSFB_F_OV_A] = ~r.blank[`SSFB_B_A_OV];
      blank_mask[SSFB_F_OC2_A] = ~r.blank[`SSFB_B_A_OC2];
      blank_mask[SSFB_F_OC1_A] = ~r.blank[`SSFB_B_A_OC1];
    end
    if (soft_start[1]) begin
      blank_mask[SSFB_F_REV_B] = 1'b1;
      blank_mask[SSFB_F_UV_B] = 1'b1;
      blank_mask[SSFB_F_OV_B] = ~r.blank[`SSFB_B_B_OV];
      blank_mask[SSFB_F_OC2_B] = ~r.blank[`SSFB_B_B_OC2];
      blank_mask[SSFB_F_OC1_B] = ~r.blank[`SSFB_B_B_OC1];
    end
    if (soft_start[2]) begin
      blank_mask[SSFB_F_OC_C] = ~r.blank[`SSFB_B_C_OC];
    end
    // The reenable window is global to all channels, ahead of any soft start.
    if (reenable_period && r.ctrl[`SSFB_C_LINE_REEN]) begin
      blank_mask[SSFB_F_LINE] = 1'b1;
    end
  end

  // Raw flags stay visible elsewhere; only the acting copy is masked.
  assign acted = flag_raw & ~blank_mask;

  // All next-state logic for registers, flags and debounce.
  always_comb begin
    next_r = r;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    // Registers keep all eight bits; bit 7 has no effect in blank and ctrl, but in deb it is the top bit of the B on-delay field.
    if (wr_en) begin
      next_r.pready = 1'b1;
      unique case (paddr[17:0])
        `SSFB_ADDR_BLANK: if (pstrb[0]) next_r.blank = pwdata[7:0];
        `SSFB_ADDR_CTRL: if (pstrb[0]) next_r.ctrl = pwdata[7:0];
        `SSFB_ADDR_DEB: if (pstrb[0]) next_r.deb = pwdata[7:0];
        `SSFB_ADDR_STATUS: next_r.pslverr = 1'b0;
        default: next_r.pslverr = 1'b1;
      endcase
      if (paddr[31:18] != 14'h0000) next_r.pslverr = 1'b1;
    end
    if (rd_en) begin
      next_r.pready = 1'b1;
      unique case (paddr[17:0])
        `SSFB_ADDR_BLANK: next_r.prdata = {24'h000000, r.blank};
        `SSFB_ADDR_CTRL: next_r.prdata = {24'h000000, r.ctrl};
        `SSFB_ADDR_DEB: next_r.prdata = {24'h000000, r.deb};
        `SSFB_ADDR_STATUS: next_r.prdata = {24'h000000, r.pg, r.first_seen, 1'b0, r.first_id};
        default: begin
          next_r.prdata = 32'h00000000;
          next_r.pslverr = 1'b1;
        end
      endcase
      if (paddr[31:18] != 14'h0000) next_r.pslverr = 1'b1;
    end
    next_r.act = acted;
    // First unblanked flag identity is captured once and stored when enabled.
    next_r.store_req = 1'b0;
    if (!r.first_seen && (|acted)) begin
      next_r.first_seen = 1'b1;
      for (int i = 14; i >= 0; i--) begin
        if (acted[i]) next_r.first_id = 4'(i);
      end
      next_r.store_req = r.ctrl[`SSFB_C_FIRST_ID];
    end
    // Shutdown timing choice; the end-of-cycle request holds until the cycle ends.
    next_r.shut_now = (|acted) & r.ctrl[`SSFB_C_IMMED];
    if ((|acted) && !r.ctrl[`SSFB_C_IMMED]) begin
      next_r.shut_eoc = 1'b1;
    end else if (pwm_cycle_end) begin
      next_r.shut_eoc = 1'b0;
    end
    // Rectifier gating: soft-start hold or else the per-output disable setting.
    for (int k = 0; k < 4; k++) begin
      next_r.rect_off[k] = rect_cfg_disable[k]
        | (soft_start[0] & r.ctrl[0] & rect_chan_a[k])
        | (soft_start[1] & r.ctrl[1] & rect_chan_b[k])
        | (soft_start[2] & r.ctrl[2] & rect_chan_c[k]);
    end
    // Balance channel is chosen outside; suspension only during its soft start.
    next_r.bal_hold = r.ctrl[`SSFB_C_BAL]
      & (bal_chan_sel_c ? soft_start[2] : soft_start[0]);
    // Power-good debounce per channel; index 0 is A, 1 is B.
    for (int c = 0; c < 2; c++) begin
      logic [1:0] on_code;
      logic [1:0] off_code;
      on_code = (c == 1) ? r.deb[`SSFB_D_B_ON +: 2] : r.deb[`SSFB_D_A_ON +: 2];
      off_code = (c == 1) ? r.deb[`SSFB_D_B_OFF +: 2] : r.deb[`SSFB_D_A_OFF +: 2];
      unique case (r.pg_st[c])
        SSFB_PG_OFF: begin
          next_r.pg_cnt[c] = 25'h0000000;
          if (pg_cond[c]) begin
            if (on_code == 2'b00) begin
              next_r.pg[c] = 1'b1;
              next_r.pg_st[c] = SSFB_PG_ON;
            end else begin
              next_r.pg_st[c] = SSFB_PG_RISE;
              next_r.pg_cnt[c] = 25'h0000001;
            end
          end
        end
        SSFB_PG_RISE: begin
          if (!pg_cond[c]) begin
            next_r.pg_st[c] = SSFB_PG_OFF;
          end else if (r.pg_cnt[c] >= ssfb_deb_cycles(on_code)) begin
            next_r.pg[c] = 1'b1;
            next_r.pg_st[c] = SSFB_PG_ON;
          end else begin
            next_r.pg_cnt[c] = r.pg_cnt[c] + 25'h0000001;
          end
        end
        SSFB_PG_ON: begin
          next_r.pg_cnt[c] = 25'h0000000;
          if (!pg_cond[c]) begin
            if (off_code == 2'b00) begin
              next_r.pg[c] = 1'b0;
              next_r.pg_st[c] = SSFB_PG_OFF;
            end else begin
              next_r.pg_st[c] = SSFB_PG_FALL;
              next_r.pg_cnt[c] = 25'h0000001;
            end
          end
        end
        SSFB_PG_FALL: begin
          if (pg_cond[c]) begin
            next_r.pg_st[c] = SSFB_PG_ON;
          end else if (r.pg_cnt[c] >= ssfb_deb_cycles(off_code)) begin
            next_r.pg[c] = 1'b0;
            next_r.pg_st[c] = SSFB_PG_OFF;
          end else begin
            next_r.pg_cnt[c] = r.pg_cnt[c] + 25'h0000001;
          end
        end
      endcase
    end
  end

  // Single state register; reset loads constants only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.blank <= `SSFB_RST_BLANK;
      r.ctrl <= `SSFB_RST_CTRL;
      r.deb <= `SSFB_RST_DEB;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign flag_active = r.act;
  assign shutdown_now = r.shut_now;
  assign shutdown_cycle_end = r.shut_eoc;
  assign first_id_store = r.store_req;
  assign first_id = r.first_id;
  assign rect_disable = r.rect_off;
  assign balance_suspend = r.bal_hold;
  assign chan_a_power_good = r.pg[0];
  assign chan_b_power_good = r.pg[1];

  // Blanked flags never reach the acting vector; further checks cover shutdown, rectifier hold, balance and power-good.
  flag_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|soft_start && flag_raw[SSFB_F_EXT]) |=> !flag_active[SSFB_F_EXT])
    else $error("Blanked external fault acted.");
  uv_a_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
    (soft_start[0] && flag_raw[SSFB_F_UV_A]) |=> !flag_active[SSFB_F_UV_A])
    else $error("Channel A undervoltage acted in soft start.");
  oc_c_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.blank[6] && flag_raw[SSFB_F_OC_C]) |=> flag_active[SSFB_F_OC_C])
    else $error("Unblanked C overcurrent dropped.");
  ov_b_blank_a: assert property (@(posedge pclk) disable iff (!presetn)
    (soft_start[1] && !r.blank[5] && flag_raw[SSFB_F_OV_B]) |=> !flag_active[SSFB_F_OV_B])
    else $error("Channel B overvoltage not blanked.");
  line_reen_a: assert property (@(posedge pclk) disable iff (!presetn)
    (reenable_period && r.ctrl[6] && flag_raw[SSFB_F_LINE]) |=> !flag_active[SSFB_F_LINE])
    else $error("Line flag acted in reenable window.");
  shut_now_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|acted && r.ctrl[4]) |=> shutdown_now)
    else $error("Immediate shutdown missing.");
  rect_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (soft_start[0] && r.ctrl[0] && rect_chan_a[0]) |=> rect_disable[0])
    else $error("Rectifier drive not held off.");
  bal_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!r.ctrl[3]) |=> !balance_suspend)
    else $error("Balance suspended while disabled.");
  pg_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.pg_st[1] == SSFB_PG_OFF && pg_cond[1] && r.deb[7:6] == 2'b00) |=> chan_b_power_good)
    else $error("Zero on-delay not immediate.");

endmodule // ssfb_top
`default_nettype wire

// File: tb/ssfb_top_tb_top.sv
// Self-checking bench for the soft-start fault blanking block.
`timescale 1ns/1ns
`default_nettype none
`include "ssfb_cfg.svh"

module ssfb_top_tb_top;
  import ssfb_pkg::*;
  typedef struct packed {logic [31:0] d; logic e; logic c;} ssfb_note_t;
  localparam logic [31:0] A_BL = {14'h0, `SSFB_ADDR_BLANK};
  localparam logic [31:0] A_CT = {14'h0, `SSFB_ADDR_CTRL};
  localparam logic [31:0] A_DB = {14'h0, `SSFB_ADDR_DEB};
  localparam logic [31:0] A_ST = {14'h0, `SSFB_ADDR_STATUS};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata;
  logic [3:0] pstrb = 0, rect_chan_a = 0, rect_chan_b = 0, rect_chan_c = 0, rect_cfg_disable = 0;
  logic pready, pslverr, reenable_period = 0, pwm_cycle_end = 0, bal_chan_sel_c = 0;
  logic [2:0] soft_start = 0;
  logic [14:0] flag_raw = 0, flag_active;
  logic [1:0] pg_cond = 0;
  logic shutdown_now, shutdown_cycle_end, first_id_store, balance_suspend;
  logic chan_a_power_good, chan_b_power_good;
  logic [3:0] first_id, rect_disable;
  int err_count = 0, tests_run = 0, store_cnt = 0;
  ssfb_note_t notes[$];
  ssfb_note_t wn;

  ssfb_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .soft_start(soft_start),
    .reenable_period(reenable_period), .flag_raw(flag_raw), .pwm_cycle_end(pwm_cycle_end),
    .bal_chan_sel_c(bal_chan_sel_c), .rect_chan_a(rect_chan_a), .rect_chan_b(rect_chan_b),
    .rect_chan_c(rect_chan_c), .rect_cfg_disable(rect_cfg_disable), .pg_cond(pg_cond),
    .flag_active(flag_active), .shutdown_now(shutdown_now),
    .shutdown_cycle_end(shutdown_cycle_end), .first_id_store(first_id_store),
    .first_id(first_id), .rect_disable(rect_disable), .balance_suspend(balance_suspend),
    .chan_a_power_good(chan_a_power_good), .chan_b_power_good(chan_b_power_good));

  // Free-running 25 MHz clock.
  always #20 pclk = ~pclk;

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic end_of_test();
    if (notes.size() != 0) err_count++;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; for a read, d is the expected data. The note is taken at pready.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic e);
    int n;
    @(posedge pclk);
    notes.push_back('{d: d, e: e, c: !wr && !e});
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? d : 32'h0;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      end_of_test();
    end
    psel <= 0;
    penable <= 0;
  endtask

  // Watcher takes the oldest note whenever a transfer completes.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      wn = notes.pop_front();
      check("pslverr", {31'h0, wn.e}, {31'h0, pslverr});
      if (wn.c) check("prdata", wn.d, prdata);
    end
    if (first_id_store === 1'b1) store_cnt++;
  end

  function automatic logic [14:0] exp_act(logic [14:0] r, logic [2:0] ss, logic [7:0] b,
                                          logic [7:0] c, logic re);
    logic [14:0] bl;
    bl = {ss[1] & ~b[1], ss[0] & ~b[0], ss[1] & ~b[3], ss[0] & ~b[2], ss[1] & ~b[5],
          ss[0] & ~b[4], ss[2] & ~b[6], ss[1], ss[0], ss[1], ss[0], (|ss) | (c[6] & re),
          {3{|ss}}};
    return r & ~bl;
  endfunction

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Watchdog so that no hang outlives the run budget.
  initial begin
    #(40 * 90000);
    err_count++;
    end_of_test();
  end

  initial begin
    logic [7:0] b, c;
    logic [2:0] ss;
    logic [14:0] r, act;
    logic re;
    logic [3:0] ra, rb, rc, cf, rx;
    void'($urandom(32'hD74B69EA));
    wait_cyc(8);
    presetn <= 1;
    apb(0, A_BL, {24'h0, `SSFB_RST_BLANK}, 4'h0, 0);
    apb(0, A_CT, {24'h0, `SSFB_RST_CTRL}, 4'h0, 0);
    apb(0, A_DB, {24'h0, `SSFB_RST_DEB}, 4'h0, 0);
    apb(1, 32'h0003F828, 32'hFF, 4'h1, 1);
    apb(0, 32'h0003F828, 32'h0, 4'h0, 1);
    apb(0, A_BL | 32'h10000000, 32'h0, 4'h0, 1);
    apb(1, A_BL, 32'hAA, 4'h1, 0);
    apb(1, A_BL, 32'h55, 4'h0, 0);
    apb(0, A_BL, 32'hAA, 4'h0, 0);
    // First flag identity is latched once, lowest index of the active set.
    apb(1, A_CT, 32'h20, 4'h1, 0);
    flag_raw <= 15'h2200;
    wait_cyc(4);
    flag_raw <= 15'h0004;
    wait_cyc(4);
    check("store_cnt", 32'd1, 32'(store_cnt));
    check("first_id", 32'd9, {28'h0, first_id});
    apb(1, A_ST, 32'hFF, 4'h1, 0);
    apb(0, A_ST, 32'h29, 4'h0, 0);
    // End-of-cycle shutdown waits for the cycle boundary; immediate shutdown stays low in this mode.
    apb(1, A_CT, 32'h00, 4'h1, 0);
    flag_raw <= 15'h0001;
    wait_cyc(3);
    check("sd_eoc", 32'd1, {31'h0, shutdown_cycle_end});
    check("sd_now", 32'd0, {31'h0, shutdown_now});
    flag_raw <= 15'h0000;
    wait_cyc(5);
    check("sd_eoc_hold", 32'd1, {31'h0, shutdown_cycle_end});
    pwm_cycle_end <= 1;
    wait_cyc(1);
    pwm_cycle_end <= 0;
    wait_cyc(3);
    check("sd_eoc_clr", 32'd0, {31'h0, shutdown_cycle_end});
    // Random configurations across soft start, blanking and rectifier gating.
    for (int i = 0; i < 40; i++) begin
      b = 8'($urandom);
      c = 8'($urandom);
      ss = 3'($urandom);
      r = 15'($urandom);
      re = 1'($urandom);
      ra = 4'($urandom);
      rb = 4'($urandom);
      rc = 4'($urandom);
      cf = 4'($urandom);
      apb(1, A_BL, {24'h0, b}, 4'h1, 0);
      apb(1, A_CT, {24'h0, c}, 4'h1, 0);
      apb(0, A_BL, {24'h0, b}, 4'h0, 0);
      apb(0, A_CT, {24'h0, c}, 4'h0, 0);
      soft_start <= ss;
      flag_raw <= r;
      reenable_period <= re;
      rect_chan_a <= ra;
      rect_chan_b <= rb;
      rect_chan_c <= rc;
      rect_cfg_disable <= cf;
      bal_chan_sel_c <= c[7] ^ b[7];
      wait_cyc(4);
      act = exp_act(r, ss, b, c, re);
      for (int k = 0; k < 4; k++) rx[k] = (|(ss & c[2:0] & {rc[k], rb[k], ra[k]})) | cf[k];
      check("flag_active", {17'h0, act}, {17'h0, flag_active});
      check("rect_disable", {28'h0, rx}, {28'h0, rect_disable});
      check("bal_susp", {31'h0, c[3] & ((c[7] ^ b[7]) ? ss[2] : ss[0])},
            {31'h0, balance_suspend});
      check("sd_now", {31'h0, c[4] & (|act)}, {31'h0, shutdown_now});
      if (!c[4] && (|act)) check("sd_eoc", 32'd1, {31'h0, shutdown_cycle_end});
    end
    // Power-good debounce: code zero follows at once, nonzero codes hold off.
    apb(1, A_DB, 32'h00, 4'h1, 0);
    pg_cond <= 2'b11;
    wait_cyc(3);
    check("pg", 32'd3, {30'h0, chan_b_power_good, chan_a_power_good});
    apb(1, A_DB, 32'hE4, 4'h1, 0);
    apb(0, A_DB, 32'hE4, 4'h0, 0);
    pg_cond <= 2'b10;
    wait_cyc(3);
    check("pg_a_off", 32'd2, {30'h0, chan_b_power_good, chan_a_power_good});
    pg_cond <= 2'b00;
    wait_cyc(100);
    check("pg_b_off", 32'd2, {30'h0, chan_b_power_good, chan_a_power_good});
    end_of_test();
  end
endmodule // ssfb_top_tb_top
`default_nettype wire
